// ### verilog/buck_regs_map.svh
// register offsets, field positions and reset values of the converter register bank
// assumes it is included by its bare name from the design
`ifndef BUCK_REGS_MAP_SVH
`define BUCK_REGS_MAP_SVH
`define FLOOR_VOLTAGE_SETTING_ADDR 2'h0
`define ROOF_VOLTAGE_SETTING_ADDR 2'h1
`define OPERATING_MODE_CONTROL_ADDR 2'h2
`define DISCHARGE_STATUS_RAMP_CONTROL_ADDR 2'h3
`define ON_BIT 7
`define SPARE_BIT 6
`define CODE_MSB 5
`define MODE_CTRL_MSB 3
`define MODE_CTRL_LSB 2
`define ROOF_CHOICE_BIT 1
`define FLOOR_CHOICE_BIT 0
`define MODE_SPARE_MSB 5
`define MODE_SPARE_LSB 4
`define DISCHARGE_BIT 6
`define GOOD_BIT 5
`define RAMP_MSB 2
`define RAMP_SPARE_MSB 4
`define RAMP_SPARE_LSB 3
`define CTRL2_SPARE_HI 7
`define ON_BIT_RESET 1'h1
`define SPARE_RESET 1'h0
`define MODE_CONTROL_RESET 8'h00
`define DISCHARGE_RESET 1'h1
`define RAMP_RESET 3'h7
`define CTRL2_SPARE_RESET 3'h0
`define MODE_DEFER 2'h0
`define MODE_FORCE_PWM 2'h2
`define REG_ADDR_HI_ZERO 6'h00
`endif

// ### verilog/buck_regs_pkg.sv
// types shared by the converter register bank
// assumes nothing beyond the map header
package buck_regs_pkg;
	typedef enum logic {
		op_auto_pfm_pwm,
		op_forced_pwm
	} operating_mode_t;
endpackage

// ### verilog/buck_voltage_mode_regs.sv
// register bank of an i2c-controlled step-down converter with its control outputs
// assumes a same-clock byte-level i2c engine in front and raw pins on enable and voltage select
//
// What this block does
// - converter runs only when converter on bit is one and power-on pin high.
// - converter on bit is one shared bit seen at bit 7 of both voltage registers.
// - floor voltage code is 6 bits in bits 5 to 0, 12.5 mV steps.
// - roof voltage code is 6 bits in bits 5 to 0, 12.5 mV steps.
// - codes reset to factory default; on bit resets to 1, spare bit 6 to 0.
// - mode field 00 defers, 01 and 11 force auto mode, 10 forces pwm.
// - with field 00 and select high, roof choice 0 gives pwm, 1 auto.
// - with select low, auto mode unless field is 10; floor choice stored but unused.
// - discharge bit drains output while disabled; no discharge when 0; resets to 1.
// - regulation good flag reads 1 while output in regulation, else 0.
// - 3-bit ramp code selects slew rate; 111 immediate; resets to 111.
// - bus access refused in hardware shutdown, available while on bit is 0.
`timescale 1ns/1ps
`include "buck_regs_map.svh"
module buck_voltage_mode_regs
	import buck_regs_pkg::*;
#(
	parameter logic [5:0] FLOOR_CODE_DEFAULT = 6'h00,
	parameter logic [5:0] ROOF_CODE_DEFAULT  = 6'h00
) (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       power_on_pin,
	input  wire logic       voltage_select_pin,
	input  wire logic       output_in_regulation,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_address,
	input  wire logic [7:0] reg_write_data,
	output logic      [7:0] reg_read_data,
	output logic            reg_ack,
	output logic            converter_run,
	output logic            discharge_on,
	output logic      [5:0] target_code,
	output logic            forced_pwm,
	output logic      [2:0] ramp_rate_code
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] power_on_sync_r;
	logic [1:0] power_on_sync_nxt;
	logic [1:0] select_sync_r;
	logic [1:0] select_sync_nxt;
	logic [1:0] good_sync_r;
	logic [1:0] good_sync_nxt;
	logic       power_on;
	logic       select_high;

	// shift each pin through two flops
	always_comb begin
		power_on_sync_nxt = {power_on_sync_r[0], power_on_pin};
		select_sync_nxt   = {select_sync_r[0], voltage_select_pin};
		good_sync_nxt     = {good_sync_r[0], output_in_regulation};
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			power_on_sync_r <= 2'h0;
			select_sync_r   <= 2'h0;
			good_sync_r     <= 2'h0;
		end else begin
			power_on_sync_r <= power_on_sync_nxt;
			select_sync_r   <= select_sync_nxt;
			good_sync_r     <= good_sync_nxt;
		end
	end

	assign power_on    = power_on_sync_r[1];
	assign select_high = select_sync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// register storage
	logic       on_bit_r;
	logic       on_bit_nxt;
	logic [1:0] spare6_r;
	logic [1:0] spare6_nxt;
	logic [5:0] floor_code_r;
	logic [5:0] floor_code_nxt;
	logic [5:0] roof_code_r;
	logic [5:0] roof_code_nxt;
	logic [5:0] mode_ctrl_r;
	logic [5:0] mode_ctrl_nxt;
	logic       discharge_r;
	logic       discharge_nxt;
	logic [2:0] ramp_r;
	logic [2:0] ramp_nxt;
	logic [2:0] ctrl2_spare_r;
	logic [2:0] ctrl2_spare_nxt;
	logic       addr_ok;
	logic       wr_go;
	logic [1:0] idx;

	assign idx     = reg_address[1:0];
	assign addr_ok = (reg_address[7:2] == `REG_ADDR_HI_ZERO);
	assign wr_go   = reg_write && power_on && addr_ok;

	// write decode; free bits simply hold what was written
	always_comb begin
		on_bit_nxt      = on_bit_r;
		spare6_nxt      = spare6_r;
		floor_code_nxt  = floor_code_r;
		roof_code_nxt   = roof_code_r;
		mode_ctrl_nxt   = mode_ctrl_r;
		discharge_nxt   = discharge_r;
		ramp_nxt        = ramp_r;
		ctrl2_spare_nxt = ctrl2_spare_r;
		if (wr_go) begin
			unique case (idx)
				`FLOOR_VOLTAGE_SETTING_ADDR: begin
					on_bit_nxt     = reg_write_data[`ON_BIT];
					spare6_nxt[0]  = reg_write_data[`SPARE_BIT];
					floor_code_nxt = reg_write_data[`CODE_MSB:0];
				end
				`ROOF_VOLTAGE_SETTING_ADDR: begin
					on_bit_nxt    = reg_write_data[`ON_BIT];
					spare6_nxt[1] = reg_write_data[`SPARE_BIT];
					roof_code_nxt = reg_write_data[`CODE_MSB:0];
				end
				`OPERATING_MODE_CONTROL_ADDR: begin
					mode_ctrl_nxt = reg_write_data[`MODE_SPARE_MSB:0]; // bits 7:6 read only
				end
				`DISCHARGE_STATUS_RAMP_CONTROL_ADDR: begin
					discharge_nxt   = reg_write_data[`DISCHARGE_BIT];
					ramp_nxt        = reg_write_data[`RAMP_MSB:0];
					ctrl2_spare_nxt = {reg_write_data[`CTRL2_SPARE_HI],
						reg_write_data[`RAMP_SPARE_MSB:`RAMP_SPARE_LSB]};
				end
			endcase
		end
	end

	// reset loads documented defaults and factory voltage codes
	always_ff @(posedge clock) begin
		if (reset) begin
			on_bit_r      <= `ON_BIT_RESET;
			spare6_r      <= {`SPARE_RESET, `SPARE_RESET};
			floor_code_r  <= FLOOR_CODE_DEFAULT;
			roof_code_r   <= ROOF_CODE_DEFAULT;
			mode_ctrl_r   <= 6'(`MODE_CONTROL_RESET); // bits 7:6 are not stored
			discharge_r   <= `DISCHARGE_RESET;
			ramp_r        <= `RAMP_RESET;
			ctrl2_spare_r <= `CTRL2_SPARE_RESET;
		end else begin
			on_bit_r      <= on_bit_nxt;
			spare6_r      <= spare6_nxt;
			floor_code_r  <= floor_code_nxt;
			roof_code_r   <= roof_code_nxt;
			mode_ctrl_r   <= mode_ctrl_nxt;
			discharge_r   <= discharge_nxt;
			ramp_r        <= ramp_nxt;
			ctrl2_spare_r <= ctrl2_spare_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operating mode decode
	function automatic operating_mode_t pick_mode(input logic [1:0] ctrl,
		input logic roof_choice, input logic sel_high);
		operating_mode_t m;
		m = op_auto_pfm_pwm;
		if (ctrl == `MODE_FORCE_PWM) begin
			m = op_forced_pwm;
		end else if (ctrl == `MODE_DEFER && sel_high && !roof_choice) begin
			m = op_forced_pwm;
		end
		// select low gives auto unless ctrl forces pwm; floor choice not consulted
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// outputs and read path
	logic [7:0] rd_nxt;
	logic       ack_nxt;
	logic       run_nxt;
	logic       dis_nxt;
	logic [5:0] tgt_nxt;
	logic       pwm_nxt;

	always_comb begin
		run_nxt = on_bit_r && power_on;
		dis_nxt = discharge_r && !run_nxt;
		tgt_nxt = select_high ? roof_code_r : floor_code_r;
		pwm_nxt = (pick_mode(mode_ctrl_r[`MODE_CTRL_MSB:`MODE_CTRL_LSB],
			mode_ctrl_r[`ROOF_CHOICE_BIT], select_high) == op_forced_pwm);
		ack_nxt = (reg_write || reg_read) && power_on && addr_ok;
		rd_nxt  = reg_read_data;
		if (reg_read && power_on) begin
			rd_nxt = 8'h00;
			if (addr_ok) begin
				unique case (idx)
					`FLOOR_VOLTAGE_SETTING_ADDR:
						rd_nxt = {on_bit_r, spare6_r[0], floor_code_r};
					`ROOF_VOLTAGE_SETTING_ADDR:
						rd_nxt = {on_bit_r, spare6_r[1], roof_code_r};
					`OPERATING_MODE_CONTROL_ADDR:
						rd_nxt = {2'h0, mode_ctrl_r};
					`DISCHARGE_STATUS_RAMP_CONTROL_ADDR:
						rd_nxt = {ctrl2_spare_r[2], discharge_r, good_sync_r[1],
							ctrl2_spare_r[1:0], ramp_r};
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reg_read_data  <= 8'h00;
			reg_ack        <= 1'h0;
			converter_run  <= 1'h0;
			discharge_on   <= 1'h0;
			target_code    <= 6'h00;
			forced_pwm     <= 1'h0;
			ramp_rate_code <= `RAMP_RESET;
		end else begin
			reg_read_data  <= rd_nxt;
			reg_ack        <= ack_nxt;
			converter_run  <= run_nxt;
			discharge_on   <= dis_nxt;
			target_code    <= tgt_nxt;
			forced_pwm     <= pwm_nxt;
			ramp_rate_code <= ramp_r;
		end
	end

endmodule

// ### testbench/buck_regs_properties.sv
// assertions on the converter register bank ports
// assumes one-cycle access strobes and a synchronous reset
`timescale 1ns/1ps
module buck_regs_checker (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       power_on_pin,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_address,
	input wire logic [7:0] reg_write_data,
	input wire logic       reg_ack,
	input wire logic       converter_run,
	input wire logic       discharge_on,
	input wire logic       forced_pwm,
	input wire logic [2:0] ramp_rate_code
);
	logic req;
	// any access strobe
	assign req = reg_write | reg_read;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	property p_bad; req && reg_address[7:2] != 6'h00 |=> !reg_ack; endproperty
	a_bad: assert property (p_bad) else $error("ack on bad address");
	property p_off;
		req && !power_on_pin && !$past(power_on_pin) && !$past(power_on_pin, 2) |=> !reg_ack;
	endproperty
	a_off: assert property (p_off) else $error("ack while powered off");
	property p_cause; reg_ack |-> $past(req); endproperty
	a_cause: assert property (p_cause) else $error("ack without access");
	property p_disch; converter_run && $past(converter_run) |-> !discharge_on; endproperty
	a_disch: assert property (p_disch) else $error("discharge while running");
	property p_run; converter_run |-> $past(power_on_pin, 3); endproperty
	a_run: assert property (p_run) else $error("run without power pin");
	property p_ramp; !$past(reg_write) && !$past(reg_write, 2) |-> $stable(ramp_rate_code); endproperty
	a_ramp: assert property (p_ramp) else $error("ramp code moved");
	property p_auto;
		reg_ack && $past(reg_write && reg_address == 8'h02 && reg_write_data[2]) |=> !forced_pwm;
	endproperty
	a_auto: assert property (p_auto) else $error("pwm under auto field");
	property p_pwm;
		reg_ack && $past(reg_write && reg_address == 8'h02 && reg_write_data[3:2] == 2'h2)
			|=> forced_pwm;
	endproperty
	a_pwm: assert property (p_pwm) else $error("no pwm under forced field");
	c_refused: cover property (req && !power_on_pin ##1 !reg_ack);
	c_pwm: cover property ($rose(forced_pwm));
	c_stop: cover property ($fell(converter_run));
endmodule
bind buck_voltage_mode_regs buck_regs_checker chk_u (.clock(clock), .reset(reset),
	.power_on_pin(power_on_pin), .reg_write(reg_write), .reg_read(reg_read),
	.reg_address(reg_address), .reg_write_data(reg_write_data), .reg_ack(reg_ack),
	.converter_run(converter_run), .discharge_on(discharge_on), .forced_pwm(forced_pwm),
	.ramp_rate_code(ramp_rate_code));

// ### testbench/bus_master_model.sv
// byte-level bus master standing in for the serial host
// assumes the bank registers its answer on the taking edge, read back half a cycle later
`timescale 1ns/1ps
module bus_master_model (
	input  wire logic       clock,
	input  wire logic       reg_ack,
	input  wire logic [7:0] reg_read_data,
	output logic            reg_write,
	output logic            reg_read,
	output logic      [7:0] reg_address,
	output logic      [7:0] reg_write_data
);
	// idle bus at time zero
	initial begin
		reg_write = 1'h0;
		reg_read = 1'h0;
		reg_address = 8'hff;
		reg_write_data = 8'hff;
	end
	// one strobe cycle, answer taken in the next; lines left inverted afterwards
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic k);
		@(negedge clock);
		reg_write = w;
		reg_read = !w;
		reg_address = a;
		reg_write_data = d;
		@(negedge clock);
		k = reg_ack;
		q = reg_read_data;
		reg_write = 1'h0;
		reg_read = 1'h0;
		reg_address = ~a;
		reg_write_data = ~d;
	endtask
endmodule

// ### testbench/buck_voltage_mode_regs_tb_top.sv
// self-checking bench for the converter register bank
// assumes the bus master model and the bound checker
`timescale 1ns/1ps
module buck_voltage_mode_regs_tb_top;
	logic       clock, reset, power_on_pin, voltage_select_pin, output_in_regulation;
	logic       reg_write, reg_read, reg_ack, converter_run, discharge_on, forced_pwm, k;
	logic [7:0] reg_address, reg_write_data, reg_read_data, q;
	logic [5:0] target_code;
	logic [2:0] ramp_rate_code;
	int         errors, checks_done, cycles;
	logic [7:0] rows [5][4];
	buck_voltage_mode_regs #(.FLOOR_CODE_DEFAULT(6'h15), .ROOF_CODE_DEFAULT(6'h2a)) dut_u (
		.clock(clock), .reset(reset), .power_on_pin(power_on_pin),
		.voltage_select_pin(voltage_select_pin), .output_in_regulation(output_in_regulation),
		.reg_write(reg_write), .reg_read(reg_read), .reg_address(reg_address),
		.reg_write_data(reg_write_data), .reg_read_data(reg_read_data), .reg_ack(reg_ack),
		.converter_run(converter_run), .discharge_on(discharge_on), .target_code(target_code),
		.forced_pwm(forced_pwm), .ramp_rate_code(ramp_rate_code));
	bus_master_model master_u (.clock(clock), .reg_ack(reg_ack), .reg_read_data(reg_read_data),
		.reg_write(reg_write), .reg_read(reg_read), .reg_address(reg_address),
		.reg_write_data(reg_write_data));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		master_u.access(1'h1, a, d, q, k);
	endtask
	task automatic rd(input logic [7:0] a);
		master_u.access(1'h0, a, 8'h00, q, k);
	endtask
	task automatic wt;
		repeat (4) @(negedge clock);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// free-running clock
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			give_verdict;
		end
	end
	// main sequence
	initial begin
		reset = 1'h1;
		power_on_pin = 1'h1;
		voltage_select_pin = 1'h1;
		output_in_regulation = 1'h1;
		rows = '{'{8'h00, 8'hff, 8'h00, 8'hff}, '{8'h01, 8'h2a, 8'h00, 8'h7f},
			'{8'h01, 8'hc0, 8'h01, 8'hc0}, '{8'h02, 8'hff, 8'h02, 8'h3f},
			'{8'h03, 8'h00, 8'h03, 8'h20}};
		repeat (20) @(negedge clock);
		reset = 1'h0;
		repeat (3) @(negedge clock);
		for (int i = 0; i < 5; i++) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][2]);
			chk("row", q, rows[i][3]);
		end
		for (int m = 0; m < 4; m++) begin
			wr(8'h02, 8'(m << 2));
			wt;
			chk("pwm", forced_pwm, {7'h00, ~m[0]});
		end
		chk("target", target_code, 8'h00);
		wr(8'h02, 8'h02);
		wt;
		chk("pwm", forced_pwm, 8'h00);
		wr(8'h02, 8'h00);
		voltage_select_pin = 1'h0;
		wt;
		chk("pwm", forced_pwm, 8'h00);
		chk("target", target_code, 8'h3f);
		wr(8'h02, 8'h08);
		wt;
		chk("pwm", forced_pwm, 8'h01);
		for (int i = 0; i < 8; i++) begin
			wr(8'h03, 8'(i));
			wt;
			chk("ramp", ramp_rate_code, 8'(i));
		end
		wr(8'h00, 8'h3f);
		wt;
		chk("run", converter_run, 8'h00);
		chk("disch", discharge_on, 8'h00);
		wr(8'h03, 8'h40);
		wt;
		chk("disch", discharge_on, 8'h01);
		rd(8'h01);
		chk("ack", k, 8'h01);
		chk("mirror", q, 8'h40);
		wr(8'h01, 8'hc0);
		wt;
		chk("run", converter_run, 8'h01);
		chk("disch", discharge_on, 8'h00);
		power_on_pin = 1'h0;
		wt;
		chk("run", converter_run, 8'h00);
		chk("disch", discharge_on, 8'h01);
		wr(8'h03, 8'h07);
		chk("ack", k, 8'h00);
		power_on_pin = 1'h1;
		wt;
		rd(8'h03);
		chk("kept", q, 8'h60);
		output_in_regulation = 1'h0;
		wt;
		rd(8'h03);
		chk("good", q, 8'h40);
		output_in_regulation = 1'h1;
		wr(8'h04, 8'h00);
		chk("ack", k, 8'h00);
		rd(8'h00);
		chk("kept", q, 8'hbf);
		reset = 1'h1;
		repeat (20) @(negedge clock);
		reset = 1'h0;
		repeat (3) @(negedge clock);
		chk("ramp", ramp_rate_code, 8'h07);
		rd(8'h00);
		chk("reset", q, 8'h95);
		rd(8'h01);
		chk("reset", q, 8'haa);
		rd(8'h02);
		chk("reset", q, 8'h00);
		rd(8'h03);
		chk("reset", q, 8'h67);
		give_verdict;
	end
endmodule
